//--- logic/phy_pin_logic.sv
/*
 * Pin-level logic of a 10/100 transceiver at its MAC side: strap capture
 * on reset release, the two status lamps, carrier sense, and the MII/RMII
 * transmit and receive data paths.
 * Assumes the link clock (MII transmit clock or RMII reference) is far
 * slower than core_clk so its edges can be found by sampling.
 */
`timescale 1ns/1ps
module phy_pin_logic
	import phy_pins_pkg::*;
#(
	parameter int unsigned BLINK_CYC = phy_pins_pkg::BLINK_CYCLES
) (
	input  wire logic              core_clk,
	input  wire logic              resetn,
	// Strap pins: carrier sense / mode bit 1, lamp A, lamp B.
	input  wire logic              crs_pin_i,
	output logic                   crs_pin_o,
	output logic                   crs_pin_oe,
	input  wire logic              status_lamp_a_i,
	output logic                   status_lamp_a_o,
	output logic                   status_lamp_a_oe,
	input  wire logic              status_lamp_b_i,
	output logic                   status_lamp_b_o,
	output logic                   status_lamp_b_oe,
	// Captured straps.
	output logic                   mode_strap_bit1_q,
	output logic                   autoneg_strap_q,
	output logic                   speed_100_q,
	output logic                   adv_100_q,
	output logic [phy_pins_pkg::CTRL_WIDTH-1:0] ctrl_straps_q,
	// Core-side status and configuration.
	input  wire logic [phy_pins_pkg::LAMP_MODE_MSB:
	                   phy_pins_pkg::LAMP_MODE_LSB] lamp_mode,
	input  wire logic              rmii_sel,
	input  wire logic              link_up,
	input  wire logic              activity,
	input  wire logic              op_speed_100,
	input  wire logic              carrier,
	// MAC link clock and transmit pins.
	input  wire logic              link_clk,
	input  wire logic              tx_en_pin,
	input  wire logic [3:0]        txd_pin,
	output logic [3:0]             tx_data_q,
	output logic                   tx_valid_q,
	// Receive data toward the MAC.
	input  wire logic [3:0]        rx_data,
	input  wire logic              rx_dv,
	output logic [3:0]             rxd_pin_q,
	output logic                   rx_dv_pin_q,
	output logic                   rx_take_q
);
	import phy_pins_pkg::*;

	pin_state_t state_q;
	logic [2:0] strap_m_q;
	logic [2:0] strap_s_q;
	logic [2:0] lclk_q;
	logic       txen_m_q;
	logic       txen_s_q;
	logic [3:0] txd_m_q;
	logic [3:0] txd_s_q;
	logic       link_rise;
	logic       blink_tick;
	logic       blink_q;
	logic       run;

	assign run       = (state_q == ST_RUN);
	assign link_rise = lclk_q[1] & ~lclk_q[2];

	// Pin synchronisers carry no reset so they track the pulls during reset.
	always_ff @(posedge core_clk) begin
		strap_m_q <= {status_lamp_b_i, status_lamp_a_i, crs_pin_i};
		strap_s_q <= strap_m_q;
		lclk_q    <= {lclk_q[1], lclk_q[0], link_clk};
		txen_m_q  <= tx_en_pin;
		txen_s_q  <= txen_m_q;
		txd_m_q   <= txd_pin;
		txd_s_q   <= txd_m_q;
	end

	// Reset phase: hold, capture once after release, then run.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			state_q <= ST_RESET;
		end else begin
			case (state_q)
				ST_RESET:   state_q <= ST_CAPTURE;
				ST_CAPTURE: state_q <= ST_RUN;
				ST_RUN:     state_q <= ST_RUN;
				default:    state_q <= ST_RESET;
			endcase
		end
	end

	// Straps are sampled on the release edge of the chip reset.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			mode_strap_bit1_q <= MODE1_RST;
			autoneg_strap_q   <= AUTONEG_RST;
			speed_100_q       <= SPEED_RST;
			adv_100_q         <= SPEED_RST;
			ctrl_straps_q     <= '0;
		end else if (state_q == ST_RESET) begin
			mode_strap_bit1_q <= strap_s_q[0];
			autoneg_strap_q   <= strap_s_q[1];
			speed_100_q       <= strap_s_q[2];
			adv_100_q         <= strap_s_q[2];
			ctrl_straps_q                   <= '0;
			ctrl_straps_q[CTRL_AUTONEG_BIT] <= strap_s_q[1];
			ctrl_straps_q[CTRL_SPEED_BIT]   <= strap_s_q[2];
		end
	end

	// Pins stay released to their pulls until the straps are taken.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			crs_pin_oe       <= 1'b0;
			status_lamp_a_oe <= 1'b0;
			status_lamp_b_oe <= 1'b0;
		end else begin
			crs_pin_oe       <= (state_q != ST_RESET);
			status_lamp_a_oe <= (state_q != ST_RESET);
			status_lamp_b_oe <= (state_q != ST_RESET);
		end
	end

	blink_divider #(
		.CYCLES   (BLINK_CYC)
	) u_blink (
		.core_clk (core_clk),
		.resetn   (resetn),
		.tick_q   (blink_tick)
	);

	// The blink phase restarts lit so a short burst still shows.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			blink_q <= 1'b0;
		end else if (!activity) begin
			blink_q <= 1'b0;
		end else if (blink_tick) begin
			blink_q <= ~blink_q;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			status_lamp_a_o <= LAMP_OFF;
		end else begin
			case (lamp_mode)
				LAMP_MODE_0: begin
					if (!link_up) begin
						status_lamp_a_o <= LAMP_OFF;
					end else if (activity) begin
						status_lamp_a_o <= blink_q;
					end else begin
						status_lamp_a_o <= ~LAMP_OFF;
					end
				end
				LAMP_MODE_1: status_lamp_a_o <= ~link_up;
				default:     status_lamp_a_o <= LAMP_OFF;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			status_lamp_b_o <= LAMP_OFF;
		end else begin
			case (lamp_mode)
				LAMP_MODE_0: status_lamp_b_o <= ~op_speed_100;
				LAMP_MODE_1: begin
					status_lamp_b_o <= activity ? blink_q : LAMP_OFF;
				end
				default:     status_lamp_b_o <= LAMP_OFF;
			endcase
		end
	end

	// RMII carries carrier on the data-valid pin instead.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			crs_pin_o <= 1'b0;
		end else begin
			crs_pin_o <= run & ~rmii_sel & carrier;
		end
	end

	// Transmit: synced data is aligned with the synced clock edge.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			tx_data_q  <= '0;
			tx_valid_q <= 1'b0;
		end else begin
			tx_valid_q <= 1'b0;
			if (run && link_rise && txen_s_q) begin
				tx_valid_q <= 1'b1;
				if (rmii_sel) begin
					tx_data_q <= {2'h0, txd_s_q[1:0]};
				end else begin
					tx_data_q <= txd_s_q;
				end
			end
		end
	end

	// Receive: pins change just after a link edge, stable for the next.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			rxd_pin_q   <= '0;
			rx_dv_pin_q <= 1'b0;
			rx_take_q   <= 1'b0;
		end else begin
			rx_take_q <= 1'b0;
			if (run && link_rise) begin
				rx_dv_pin_q <= rx_dv;
				rx_take_q   <= rx_dv;
				if (!rx_dv) begin
					rxd_pin_q <= '0;
				end else if (rmii_sel) begin
					rxd_pin_q <= {2'h0, rx_data[1:0]};
				end else begin
					rxd_pin_q <= rx_data;
				end
			end
		end
	end

endmodule : phy_pin_logic

//--- logic/phy_pins_pkg.sv
/*
 * Shared constants for the pin-level strap, lamp and MAC-facing logic.
 * Assumes a single 20 MHz core clock and no register bus.
 */
package phy_pins_pkg;

	localparam longint CORE_CLK_HZ      = 20000000;
	// Half period of the activity blink, in milliseconds.
	localparam longint BLINK_HALF_MS    = 100;
	localparam longint BLINK_CYCLES_L   = (BLINK_HALF_MS * CORE_CLK_HZ) / 1000;
	localparam int     BLINK_CYCLES     = int'(BLINK_CYCLES_L);

	// Control register 0h field positions fed by straps.
	localparam int     CTRL_AUTONEG_BIT = 12;
	localparam int     CTRL_SPEED_BIT   = 13;
	localparam int     CTRL_WIDTH       = 16;
	// Lamp mode field position in register 1Fh.
	localparam int     LAMP_MODE_LSB    = 4;
	localparam int     LAMP_MODE_MSB    = 5;

	// Values assumed before straps are captured (autoneg and speed pulled up, mode bit 1 pulled down).
	localparam logic   AUTONEG_RST      = 1'b1;
	localparam logic   SPEED_RST        = 1'b1;
	localparam logic   MODE1_RST        = 1'b0;
	localparam logic   LAMP_OFF         = 1'b1;

	localparam logic [1:0] LAMP_MODE_0  = 2'h0;
	localparam logic [1:0] LAMP_MODE_1  = 2'h1;

	typedef enum logic [1:0] {
		ST_RESET   = 2'h0,
		ST_CAPTURE = 2'h1,
		ST_RUN     = 2'h3
	} pin_state_t;

endpackage : phy_pins_pkg

//--- logic/blink_divider.sv
/*
 * Free-running divider giving a one-cycle enable every CYCLES clocks.
 * Assumes the caller gates the result with its own activity condition.
 */
`timescale 1ns/1ps
module blink_divider #(
	parameter int unsigned CYCLES = 16
) (
	input  wire logic core_clk,
	input  wire logic resetn,
	output logic      tick_q
);
	localparam int unsigned CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	logic [CW-1:0] count_q;

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			count_q <= '0;
			tick_q  <= 1'b0;
		end else begin
			tick_q <= (count_q == LAST);
			if (count_q == LAST) begin
				count_q <= '0;
			end else begin
				count_q <= count_q + CW'(1);
			end
		end
	end

endmodule : blink_divider

//--- dv/phy_pin_checker.sv
/* Port assertions for phy_pin_logic.
   Assumes one core_clk domain with a synchronous low reset. */
`timescale 1ns/1ps
module phy_pin_checker
	import phy_pins_pkg::*;
(
	input wire logic core_clk, resetn, crs_pin_i, crs_pin_o, crs_pin_oe,
	input wire logic status_lamp_a_i, status_lamp_a_o, status_lamp_a_oe,
	input wire logic status_lamp_b_i, status_lamp_b_o, status_lamp_b_oe,
	input wire logic mode_strap_bit1_q, autoneg_strap_q, speed_100_q,
	input wire logic adv_100_q, rmii_sel, link_up, op_speed_100, carrier,
	input wire logic tx_valid_q, rx_dv_pin_q, rx_take_q,
	input wire logic [CTRL_WIDTH-1:0] ctrl_straps_q,
	input wire logic [LAMP_MODE_MSB:LAMP_MODE_LSB] lamp_mode,
	input wire logic [3:0] rxd_pin_q
);
	logic run_q;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// A pin enable seen one sample back means the run state holds now.
	always_ff @(posedge core_clk) run_q <= resetn && crs_pin_oe;
	a_strap_take: assert property ($rose(resetn) |=>
		autoneg_strap_q == $past(status_lamp_a_i) &&
		speed_100_q == $past(status_lamp_b_i) &&
		mode_strap_bit1_q == $past(crs_pin_i)) else $error("Strap lost.");
	a_pin_turn: assert property ($rose(resetn) |=> !crs_pin_oe ##1
		crs_pin_oe && status_lamp_a_oe && status_lamp_b_oe)
		else $error("Pins not turned.");
	a_ctrl_image: assert property ($past(resetn) |->
		adv_100_q == speed_100_q && ctrl_straps_q ==
		{2'h0, speed_100_q, autoneg_strap_q, 12'h000})
		else $error("Control image wrong.");
	a_lamp_link: assert property (run_q && lamp_mode == LAMP_MODE_1 |=>
		status_lamp_a_o == !$past(link_up)) else $error("Lamp A wrong.");
	a_lamp_speed: assert property (run_q && lamp_mode == 2'h0 |=>
		status_lamp_b_o == !$past(op_speed_100))
		else $error("Lamp B wrong.");
	a_crs_follow: assert property (run_q |=> crs_pin_o ==
		(!$past(rmii_sel) && $past(carrier))) else $error("Carrier wrong.");
	a_tx_pulse: assert property (tx_valid_q |=> !tx_valid_q)
		else $error("Valid too long.");
	a_rx_quiet: assert property (!rx_dv_pin_q |-> rxd_pin_q == 4'h0)
		else $error("Idle receive data.");
	a_rx_take: assert property (rx_take_q |-> rx_dv_pin_q)
		else $error("Take without valid.");
endmodule : phy_pin_checker
bind phy_pin_logic phy_pin_checker i_chk (
	.core_clk(core_clk), .resetn(resetn), .crs_pin_i(crs_pin_i),
	.crs_pin_o(crs_pin_o), .crs_pin_oe(crs_pin_oe),
	.status_lamp_a_i(status_lamp_a_i),
	.status_lamp_a_o(status_lamp_a_o),
	.status_lamp_a_oe(status_lamp_a_oe),
	.status_lamp_b_i(status_lamp_b_i),
	.status_lamp_b_o(status_lamp_b_o),
	.status_lamp_b_oe(status_lamp_b_oe),
	.mode_strap_bit1_q(mode_strap_bit1_q),
	.autoneg_strap_q(autoneg_strap_q), .speed_100_q(speed_100_q),
	.adv_100_q(adv_100_q), .rmii_sel(rmii_sel), .link_up(link_up),
	.op_speed_100(op_speed_100), .carrier(carrier),
	.tx_valid_q(tx_valid_q), .rx_dv_pin_q(rx_dv_pin_q),
	.rx_take_q(rx_take_q), .ctrl_straps_q(ctrl_straps_q),
	.lamp_mode(lamp_mode), .rxd_pin_q(rxd_pin_q)
);

//--- dv/mac_model.sv
/* MAC transmit side; the link clock runs only inside a beat.
   Assumes the bench calls beats one after another. */
`timescale 1ns/1ps
module mac_model (
	output logic       link_clk = 1'b0,
	output logic       tx_en_pin = 1'b0,
	output logic [3:0] txd_pin = 4'h0
);
	// Data moves while the clock is low; a released bus shows the inverse.
	task automatic beat(input logic en, input logic [3:0] d);
		tx_en_pin <= en;
		txd_pin   <= d;
		#200 link_clk <= 1'b1;
		#200 link_clk <= 1'b0;
		tx_en_pin <= 1'b0;
		txd_pin   <= ~d;
		// Leave the edge behind so the next beat starts on a later one.
		#10;
	endtask : beat
endmodule : mac_model

//--- dv/tb_top.sv
/* Bench for phy_pin_logic with the MAC model on its link side.
   Assumes the bound checker and a blink count of 8. */
`timescale 1ns/1ps
module tb_top;
	logic core_clk = 1'b0, resetn = 1'b0, rmii_sel = 1'b0, rx_dv = 1'b1;
	logic link_up = 1'b0, activity = 1'b0, op_speed_100 = 1'b0;
	logic carrier = 1'b1, link_clk, tx_en_pin, tx_valid_q, rx_take_q;
	logic crs_pin_o, crs_pin_oe, status_lamp_a_o, status_lamp_a_oe;
	logic status_lamp_b_o, status_lamp_b_oe, mode_strap_bit1_q;
	logic autoneg_strap_q, speed_100_q, adv_100_q, rx_dv_pin_q;
	logic [2:0] pu = 3'h7;
	logic [1:0] lamp_mode = 2'h0;
	logic [3:0] txd_pin, rx_data = 4'hB, tx_data_q, rxd_pin_q;
	logic [15:0] ctrl_straps_q;
	int n_errors = 0, samples_checked = 0, hi;
	// Shared pins read the device while it drives them, else the pull.
	wire crs_pin_i = crs_pin_oe ? crs_pin_o : pu[2];
	wire status_lamp_a_i = status_lamp_a_oe ? status_lamp_a_o : pu[1];
	wire status_lamp_b_i = status_lamp_b_oe ? status_lamp_b_o : pu[0];
	phy_pin_logic #(.BLINK_CYC(8)) i_dut (
		.core_clk(core_clk), .resetn(resetn),
		.crs_pin_i(crs_pin_i), .crs_pin_o(crs_pin_o),
		.crs_pin_oe(crs_pin_oe),
		.status_lamp_a_i(status_lamp_a_i),
		.status_lamp_a_o(status_lamp_a_o),
		.status_lamp_a_oe(status_lamp_a_oe),
		.status_lamp_b_i(status_lamp_b_i),
		.status_lamp_b_o(status_lamp_b_o),
		.status_lamp_b_oe(status_lamp_b_oe),
		.mode_strap_bit1_q(mode_strap_bit1_q),
		.autoneg_strap_q(autoneg_strap_q),
		.speed_100_q(speed_100_q), .adv_100_q(adv_100_q),
		.ctrl_straps_q(ctrl_straps_q), .lamp_mode(lamp_mode),
		.rmii_sel(rmii_sel), .link_up(link_up),
		.activity(activity), .op_speed_100(op_speed_100),
		.carrier(carrier), .link_clk(link_clk),
		.tx_en_pin(tx_en_pin), .txd_pin(txd_pin),
		.tx_data_q(tx_data_q), .tx_valid_q(tx_valid_q),
		.rx_data(rx_data), .rx_dv(rx_dv),
		.rxd_pin_q(rxd_pin_q), .rx_dv_pin_q(rx_dv_pin_q),
		.rx_take_q(rx_take_q)
	);
	mac_model i_mac (
		.link_clk(link_clk), .tx_en_pin(tx_en_pin), .txd_pin(txd_pin)
	);
	initial forever #25 core_clk = ~core_clk;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic give_verdict;
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : give_verdict
	task automatic await_tx;
		int k;
		for (k = 0; k < 40 && tx_valid_q !== 1'b1; k++) @(negedge core_clk);
		if (k == 40) begin
			n_errors++;
			give_verdict;
		end
	endtask : await_tx
	task automatic do_reset(input logic [2:0] p);
		@(posedge core_clk);
		resetn <= 1'b0;
		pu <= p;
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (3) @(negedge core_clk);
		chk({mode_strap_bit1_q, autoneg_strap_q, speed_100_q}, p);
		chk({adv_100_q, ctrl_straps_q[13:12]}, {p[0], p[0], p[1]});
	endtask : do_reset
	initial begin
		do_reset(3'h5);
		do_reset(3'h2);
		for (int i = 0; i < 16; i++) begin
			@(posedge core_clk);
			lamp_mode <= i[3:2];
			{link_up, op_speed_100} <= i[1:0];
			carrier <= i[0];
			repeat (2) @(negedge core_clk);
			chk({status_lamp_a_o, status_lamp_b_o},
				{i[3] | !i[1], i[3] | i[2] | !i[0]});
			chk(crs_pin_o, i[0]);
		end
		for (int m = 0; m < 2; m++) begin
			@(posedge core_clk);
			lamp_mode <= m[1:0];
			activity <= 1'b1;
			hi = 0;
			repeat (32) @(negedge core_clk)
				hi += m ? status_lamp_b_o : status_lamp_a_o;
			chk(hi > 8 && hi < 24, 1'b1);
		end
		for (int r = 0; r < 2; r++) begin
			@(posedge core_clk);
			rmii_sel <= r[0];
			fork
				i_mac.beat(1'b1, 4'hA);
				begin
					await_tx;
					chk(tx_data_q, r ? 4'h2 : 4'hA);
					chk({rx_take_q, rxd_pin_q}, r ? 5'h13 : 5'h1B);
					chk(crs_pin_o, !r);
				end
			join
		end
		@(posedge core_clk);
		rx_dv <= 1'b0;
		hi = 0;
		fork
			i_mac.beat(1'b0, 4'h5);
			repeat (16) @(negedge core_clk) hi += tx_valid_q;
		join
		chk(hi[15:0], 16'h0000);
		chk(tx_data_q, 4'h2);
		chk({rx_dv_pin_q, rxd_pin_q}, 5'h00);
		give_verdict;
	end
endmodule : tb_top
